// >>> wdr_pkg.sv
// Purpose: Constants for the watchdog timer with reset flag logic
// Assumes: AHB-Lite register bus, 25 MHz system clock
// Notes: Register byte offsets are word aligned
package wdr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CNT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RST_CTRL = 8'h04;
  // Write keys in the upper byte of a write
  localparam logic [7:0] KEY_COUNTER = 8'h5A;
  localparam logic [7:0] KEY_CONTROL = 8'hA5;
  // Control field positions
  localparam int BIT_OVF = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_RUN = 5;
  localparam int BIT_WDOG_RESET_FLAG = 7;
  localparam int BIT_RESET_PIN_DRIVE_ENABLE = 6;
  // Reset values
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [2:0] CKS_RESET = 3'h0;
  // Reset pin pulse length in system clock periods
  localparam int RST_PULSE_CYCLES = 132;
  // Read-back filler for reserved bits
  localparam logic [7:0] CTRL_RSVD = 8'h18;
  localparam logic [7:0] RSTCTRL_RSVD = 8'h3F;
endpackage

// >>> wdr_watchdog.sv
// Purpose: 8-bit watchdog / interval timer with reset status flag and reset pin drive
// Assumes: Single AHB-Lite master, word transfers only, zero-wait answers
// Notes: Prescaler taps are chosen by the clock select field; the internal reset is a pulse
// Notes on behaviour
// R1: Reset flag matters only in watchdog mode with the timer enabled.
// R2: Watchdog mode overflow sets the reset flag.
// R3: That same overflow pulses the chip-wide internal reset.
// R4: Counter write coinciding with a tick loads data and skips increment.
// R5: Software stops the timer before changing clock select bits.
// R6: Watchdog counting starts once mode and enable bits are both one.
// R7: Interval mode overflow sets overflow flag and interrupt, no reset.
// R8: With drive enable set, reset pin is held low 132 clocks.
// R9: Writes carry a key in the upper byte; only lower byte is data.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
module wdr_watchdog
  import wdr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Events out
  output logic intervalIrq,
  output logic chipResetPulse,
  // Reset pin, open drain
  output logic resetPinOut,
  output logic resetPinOe
);

  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [7:0] timerCounter_q;
  logic overflowFlag_q;
  logic wdogModeSelect_q;
  logic timerRunEnable_q;
  logic [2:0] countClockSelect_q;
  logic wdogResetFlag_q;
  logic resetPinDriveEnable_q;
  logic [11:0] prescale_q;
  logic [11:0] prescale_d;
  logic tick;
  logic overflow;
  logic cntWrite;
  logic ctrlWrite;
  logic rstClrWrite;
  logic rstOeWrite;
  logic [7:0] pinCount_q;
  logic ovfSeenRead_q;
  logic rdCtrl;
  logic rdRst;

  // Address phase capture; only full word writes are ever acted on
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end
    else if (hready)
    begin
      wrPend_q <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      wrAddr_q <= haddr[7:0];
    end
  end

  // Write decode by key [R9]
  assign cntWrite = wrPend_q && wrAddr_q == ADDR_CNT_CTRL && hwdata[15:8] == KEY_COUNTER;
  assign ctrlWrite = wrPend_q && wrAddr_q == ADDR_CNT_CTRL && hwdata[15:8] == KEY_CONTROL;
  assign rstClrWrite = wrPend_q && wrAddr_q == ADDR_RST_CTRL && hwdata[15:8] == KEY_CONTROL
    && hwdata[7:0] == 8'h00;
  assign rstOeWrite = wrPend_q && wrAddr_q == ADDR_RST_CTRL && hwdata[15:8] == KEY_COUNTER;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Prescaler free runs while enabled; a tap rising edge is one counter tick
  assign prescale_d = prescale_q + 12'h001;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prescale_q <= 12'h000;
    else if (!timerRunEnable_q)
      prescale_q <= 12'h000;
    else
      prescale_q <= prescale_d;
  end

  // Tap select; changing it mid-run can give spurious ticks [R5]
  always_comb
  begin
    case (countClockSelect_q)
      3'h0: tick = prescale_d[0] & ~prescale_q[0];
      3'h1: tick = prescale_d[1] & ~prescale_q[1];
      3'h2: tick = prescale_d[2] & ~prescale_q[2];
      3'h3: tick = prescale_d[4] & ~prescale_q[4];
      3'h4: tick = prescale_d[5] & ~prescale_q[5];
      3'h5: tick = prescale_d[6] & ~prescale_q[6];
      3'h6: tick = prescale_d[8] & ~prescale_q[8];
      default: tick = prescale_d[11] & ~prescale_q[11];
    endcase
  end

  // Counting begins when enabled; watchdog mode needs both bits set [R6]
  assign overflow = timerRunEnable_q && tick && !cntWrite && timerCounter_q == 8'hFF;

  // Counter: a keyed write wins over a coincident tick [R4]
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      timerCounter_q <= CNT_RESET;
    else if (cntWrite)
      timerCounter_q <= hwdata[7:0]; // [R4]
    else if (timerRunEnable_q && tick)
      timerCounter_q <= timerCounter_q + 8'h01; // [R6]
  end

  // Control bits; overflow flag set wins over software clear [R7]
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wdogModeSelect_q <= 1'b0;
      timerRunEnable_q <= 1'b0;
      countClockSelect_q <= CKS_RESET;
      overflowFlag_q <= 1'b0;
      ovfSeenRead_q <= 1'b0;
    end
    else
    begin
      if (ctrlWrite)
      begin
        wdogModeSelect_q <= hwdata[BIT_MODE];
        timerRunEnable_q <= hwdata[BIT_RUN];
        countClockSelect_q <= hwdata[2:0];
      end
      if (overflow && !wdogModeSelect_q)
        overflowFlag_q <= 1'b1; // [R7]
      else if (ctrlWrite && !hwdata[BIT_OVF] && ovfSeenRead_q)
        overflowFlag_q <= 1'b0;
      // Clearing needs a read of the flag while set first
      if (rdCtrl && overflowFlag_q)
        ovfSeenRead_q <= 1'b1;
      else if (ctrlWrite)
        ovfSeenRead_q <= 1'b0;
    end
  end

  // Interval interrupt is a one-cycle request [R7]
  assign intervalIrq = overflow && !wdogModeSelect_q;
  // Internal reset only in watchdog mode with timer running [R1] [R3]
  assign chipResetPulse = overflow && wdogModeSelect_q;

  // Reset status flag: set wins over clear [R2]
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wdogResetFlag_q <= 1'b0;
      resetPinDriveEnable_q <= 1'b0;
    end
    else
    begin
      if (chipResetPulse)
        wdogResetFlag_q <= 1'b1; // [R2]
      else if (rstClrWrite)
        wdogResetFlag_q <= 1'b0;
      if (rstOeWrite)
        resetPinDriveEnable_q <= hwdata[BIT_RESET_PIN_DRIVE_ENABLE];
    end
  end

  // Reset pin pulse length counter [R8]
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pinCount_q <= 8'h00;
    else if (chipResetPulse && resetPinDriveEnable_q)
      pinCount_q <= 8'(RST_PULSE_CYCLES); // [R8]
    else if (pinCount_q != 8'h00)
      pinCount_q <= pinCount_q - 8'h01;
  end

  assign resetPinOe = pinCount_q != 8'h00; // [R8]
  assign resetPinOut = 1'b0;

  // Read data latched at the address phase so it comes from a flop; it stands
  // for the whole data phase, and the flag seen by software is the one returned
  assign rdCtrl = hready && hsel && htrans[1] && !hwrite && haddr[7:0] == ADDR_CNT_CTRL;
  assign rdRst = hready && hsel && htrans[1] && !hwrite && haddr[7:0] == ADDR_RST_CTRL;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (rdCtrl)
      hrdata <= {16'h0000, timerCounter_q, overflowFlag_q, wdogModeSelect_q, timerRunEnable_q,
        CTRL_RSVD[4:3], countClockSelect_q};
    else if (rdRst)
      hrdata <= {24'h00_0000, wdogResetFlag_q, resetPinDriveEnable_q, RSTCTRL_RSVD[5:0]}; // [R1]
    else
      hrdata <= 32'h0000_0000;
  end

  // Checks
  reset_flag_a: assert property (@(posedge clk) disable iff (reset)
    chipResetPulse |=> wdogResetFlag_q) else $error("reset flag not set"); // [R2]
  reset_mode_a: assert property (@(posedge clk) disable iff (reset) // [R1] [R3]
    wdogModeSelect_q && timerRunEnable_q && tick && !cntWrite && timerCounter_q == 8'hFF
    |-> chipResetPulse && !intervalIrq) else $error("watchdog overflow without reset");
  write_wins_a: assert property (@(posedge clk) disable iff (reset)
    cntWrite |=> timerCounter_q == $past(hwdata[7:0])) else $error("write lost"); // [R4]
  irq_nores_a: assert property (@(posedge clk) disable iff (reset)
    intervalIrq |-> !chipResetPulse ##1 overflowFlag_q) else $error("irq wrong"); // [R7]
  pin_pulse_a: assert property (@(posedge clk) disable iff (reset)
    chipResetPulse && resetPinDriveEnable_q |=> resetPinOe [*8]) else $error("pin"); // [R8]
  pin_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(resetPinOe) |-> ##131 resetPinOe ##1 !resetPinOe) else $error("pin length"); // [R8]
  key_guard_a: assert property (@(posedge clk) disable iff (reset)
    wrPend_q && hwdata[15:8] != KEY_COUNTER && hwdata[15:8] != KEY_CONTROL
    |=> $stable(timerCounter_q) || $past(tick)) else $error("keyless write"); // [R9]
  run_count_a: assert property (@(posedge clk) disable iff (reset)
    !timerRunEnable_q && !cntWrite |=> $stable(timerCounter_q)) else $error("count"); // [R6]
  ovf_irq_c: cover property (@(posedge clk) disable iff (reset) intervalIrq);
  wdog_rst_c: cover property (@(posedge clk) disable iff (reset) chipResetPulse);
  pin_drv_c: cover property (@(posedge clk) disable iff (reset) $fell(resetPinOe));
endmodule

// >>> wdr_watchdog_tb_top.sv
// Purpose: Self-checking bench for the watchdog timer through its register bus
// Assumes: Zero-wait slave, fastest clock select (2 clocks per tick)
// Notes: Event and pin outputs are sampled on the falling edge, away from register updates; read data on the rising edge
module wdr_watchdog_tb_top
  import wdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic reset = 1;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic intervalIrq;
  logic chipResetPulse;
  logic resetPinOut;
  logic resetPinOe;
  logic [31:0] rdat;
  logic [2:0] sz = 3'h2;
  int failures = 0;
  int nCompared = 0;
  int n;
  // Single slave, so its ready is the bus ready
  wdr_watchdog wdr_watchdog_i (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .intervalIrq(intervalIrq),
    .chipResetPulse(chipResetPulse), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));
  always #20 clk = ~clk;
  task automatic finish_test();
    if (failures == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // Bounded wait for ready; a hung bus ends the run
  task automatic waitReady();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1)
    begin
      check("bus ready", 1, 0);
      finish_test();
    end
  endtask
  // One single transfer of size sz: address phase, then data phase
  task automatic bus(logic [7:0] a, logic w, logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rdat = hrdata;
  endtask
  task automatic rdc(string what, logic [7:0] a, logic [31:0] exp, logic [31:0] m);
    bus(a, 1'b0, 32'h0000_0000);
    check(what, exp, rdat & m);
    check("response", 0, hresp);
  endtask
  // Waits for an event pulse; the other event must stay quiet meanwhile
  task automatic waitEvent(logic wantReset);
    for (n = 0; n < 2000; n++)
    begin
      @(negedge clk);
      if ((wantReset ? intervalIrq : chipResetPulse) === 1'b1)
        check("wrong event", 0, 1);
      if ((wantReset ? chipResetPulse : intervalIrq) === 1'b1)
        break;
    end
    if (n >= 2000)
    begin
      check("event wait", 1, 0);
      finish_test();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rdc("ctrl reset", ADDR_CNT_CTRL, 32'h0000_0018, 32'hFFFF_FFFF);
    rdc("rstctrl reset", ADDR_RST_CTRL, 32'h0000_003F, 32'hFFFF_FFFF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_3377);
    rdc("bad key", ADDR_CNT_CTRL, 32'h0000_0018, 32'hFFFF_FFFF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_5AFE);
    rdc("counter load", ADDR_CNT_CTRL, 32'h0000_FE18, 32'h0000_FFFF);
    // Interval mode; clock select set only while stopped
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A520);
    waitEvent(1'b0);
    rdc("ovf set", ADDR_CNT_CTRL, 32'h0000_00B8, 32'h0000_00FF);
    rdc("no flag", ADDR_RST_CTRL, 32'h0000_003F, 32'h0000_00FF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A500);
    rdc("ovf clear", ADDR_CNT_CTRL, 32'h0000_0018, 32'h0000_00FF);
    // Slowest clock select, set while stopped; a write while running loads as written
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A507);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A527);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_5A33);
    rdc("running load", ADDR_CNT_CTRL, 32'h0000_333F, 32'h0000_FFFF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A507);
    // Byte writes are ignored
    sz = 3'h0;
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_5A55);
    sz = 3'h2;
    rdc("byte write", ADDR_CNT_CTRL, 32'h0000_331F, 32'h0000_FFFF);
    // Watchdog mode with the reset pin driven
    bus(ADDR_RST_CTRL, 1'b1, 32'h0000_5A40);
    rdc("pin enable", ADDR_RST_CTRL, 32'h0000_007F, 32'h0000_00FF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_5AFE);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A560);
    waitEvent(1'b1);
    n = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (resetPinOe === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    check("pin low cycles", RST_PULSE_CYCLES, n);
    check("pin data", 0, resetPinOut);
    rdc("flag set", ADDR_RST_CTRL, 32'h0000_00FF, 32'h0000_00FF);
    bus(ADDR_CNT_CTRL, 1'b1, 32'h0000_A500);
    bus(ADDR_RST_CTRL, 1'b1, 32'h0000_A500);
    rdc("flag clear", ADDR_RST_CTRL, 32'h0000_007F, 32'h0000_00FF);
    finish_test();
  end
endmodule
